// *** verilog/trig_qualifier.sv ***
// trigger qualifier: serial pattern, delay, edge and glitch modes
`timescale 1ns/1ps
`default_nettype none
`include "trig_qual_regs.svh"

// What this block does
// - stores one to six ternary pattern symbols
// - polarity picks edge sense and validates pattern
// - serial source is analog input 1..4
// - delay mode armed by selectable edge
// - delay counted in events or in time
// - count up to 16,000,000 events then trigger
// - event source and slope separately selectable
// - wait 10 ns to 10 s then trigger
// - final trigger edge on selectable source
// - edge fires rising, falling or either; line unsloped
// - edge source analog, logic, aux or line
// - two copies of edge and glitch settings
// - glitch fires on pulse narrower than width
// - glitch qualifies selected polarity only
// - glitch source analog or logic input
// - every setting reads back unchanged
// - serial coding selectable as RZ or NRZ
module trig_qualifier
#(
	parameter int DELAY_MAX_CYC  = `TDLY_MAX_MS * (1000000000 / `CLK_PERIOD_PS),
	parameter int GLITCH_MAX_CYC = `GLITCH_MAX_MS * (1000000000 / `CLK_PERIOD_PS)
)
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clkEn,
	input  wire logic [3:0]               analogIn,
	input  wire logic [15:0]              logicIn,
	input  wire logic                     auxIn,
	input  wire logic                     lineIn,
	input  wire logic                     cfgWr,
	input  wire logic                     cfgStage,
	input  wire trig_qual_pkg::settings_t cfgIn,
	input  wire logic                     rdStage,
	input  wire logic                     activeStage,
	output logic                          trigOut,
	output logic                          patternBad,
	output logic                          delayArmed,
	output trig_qual_pkg::settings_t      rdOut
);
	import trig_qual_pkg::*;

	// ************************************************************
	// constants and state
	// ************************************************************

	// least times round up, and never below one cycle
	localparam logic [28:0] DLY_MIN_CYC = 29'((`TDLY_MIN_NS * 1000
		+ `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS);
	localparam logic [28:0] GL_MIN_CYC = 29'((`GLITCH_MIN_PS
		+ `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS);
	localparam logic [28:0] DLY_MAX = 29'(DELAY_MAX_CYC);
	localparam logic [28:0] GL_MAX = 29'(GLITCH_MAX_CYC);

	typedef struct packed {
		trigMode_t             mode;
		serialCfg_t            serial;
		delayCfg_t             dly;
		stageCfg_t [1:0]       stage;
		logic [`SRC_COUNT-1:0] prev;
		logic [5:0]            hist;
		logic [2:0]            fill;
		logic                  matchQ;
		dlyState_t             dState;
		logic [28:0]           cnt;
		logic                  trig;
		logic                  patBad;
		logic                  armed;
		settings_t             rd;
	} qualState_t;

	qualState_t            s_q;
	qualState_t            s_d;
	logic [`SRC_COUNT-1:0] cur;
	stageCfg_t             act;
	logic                  serBit;
	logic                  valid;
	logic                  match;
	logic                  armEdge;
	logic                  evEdge;
	logic                  onEdge;
	logic                  edgeHit;
	logic                  glLvl;
	logic                  glHit;
	logic [28:0]           delayEff;
	logic [28:0]           glWidthEff;
	logic [23:0]           evEff;

	// ************************************************************
	// decoding helpers
	// ************************************************************

	// one bit of the source vector; codes past the line read as low
	function automatic logic pick(srcSel_t sel, logic [`SRC_COUNT-1:0] v);
		pick = (sel <= `SRC_LINE) ? v[sel] : 1'b0;
	endfunction

	function automatic slope_t toSlope(polarity_t p);
		toSlope = (p == POL_NEG) ? SLOPE_NEG : SLOPE_POS;
	endfunction

	// edge of the chosen slope between two successive samples
	function automatic logic srcEdge(slope_t sl, srcSel_t sel,
		logic [`SRC_COUNT-1:0] p, logic [`SRC_COUNT-1:0] c);
		logic a;
		logic b;
		a = pick(sel, p);
		b = pick(sel, c);
		case (sl)
			SLOPE_POS:    srcEdge = !a && b;
			SLOPE_NEG:    srcEdge = a && !b;
			SLOPE_EITHER: srcEdge = a != b;
			default:      srcEdge = 1'b0;
		endcase
	endfunction

	// does one sampled bit fit one pattern symbol under the coding
	function automatic logic symHit(logic [1:0] sym, logic b, serialCfg_t c);
		if (!c.rzCoding)
			symHit = (sym == `SYM_ONE) ? b : !b;
		else if (c.pol == POL_POS)
			symHit = (sym == `SYM_ONE) ? b : (sym == `SYM_ZERO) && !b;
		else
			symHit = (sym == `SYM_MINUS) ? !b : (sym == `SYM_ZERO) && b;
	endfunction

	// a pattern the front end cannot lock onto is refused, not guessed
	function automatic logic patOk(serialCfg_t c);
		logic        need;
		logic        ok;
		logic [13:0] ext;
		logic [1:0]  a;
		logic [1:0]  b;
		ext = {2'h0, c.pattern};
		need = 1'b0;
		ok = (c.patLen != 3'h0) && (c.patLen <= `PAT_MAX);
		for (int i = 0; i < 6; i++)
		begin
			a = ext[2*i +: 2];
			b = ext[2*i+2 +: 2];
			if (i < c.patLen)
			begin
				ok = ok && (a != `SYM_BAD);
				if (c.rzCoding && c.pol == POL_POS)
					need = need || (a == `SYM_ONE);
				else if (c.rzCoding)
					need = need || (a == `SYM_MINUS);
				else if (i + 1 < c.patLen && c.pol == POL_POS)
					need = need || (a != `SYM_ONE && b == `SYM_ONE);
				else if (i + 1 < c.patLen)
					need = need || (a == `SYM_ONE && b != `SYM_ONE);
			end
		end
		patOk = ok && need;
	endfunction

	// oldest stored sample lines up with symbol 0
	function automatic logic matchOf(logic [5:0] h, logic [2:0] fill,
		serialCfg_t c);
		logic m;
		m = fill >= c.patLen;
		for (int i = 0; i < 6; i++)
			if (i < c.patLen)
				m = m && symHit(c.pattern[2*i +: 2],
					h[c.patLen - 3'h1 - 3'(i)], c);
		matchOf = m;
	endfunction

	function automatic logic [28:0] clampCyc(logic [28:0] v,
		logic [28:0] lo, logic [28:0] hi);
		clampCyc = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	// ************************************************************
	// input side and per-mode detectors
	// ************************************************************

	// pins come from the comparators' own timing, so resample them
	input_sync u_sync
	(
		.clk   (clk),
		.rst_n (rst_n),
		.clkEn (clkEn),
		.din   ({lineIn, auxIn, logicIn, analogIn}),
		.dout  (cur)
	);

	// the sequencer picks which stage copy drives the detectors
	assign act = s_q.stage[activeStage];
	assign serBit = cur[s_q.serial.chan];
	assign valid = patOk(s_q.serial);
	assign match = matchOf(s_q.hist, s_q.fill, s_q.serial);

	// delay mode edges, each with its own source and slope
	assign armEdge = srcEdge(toSlope(s_q.dly.armSlope), s_q.dly.armSrc,
		s_q.prev, cur);
	assign evEdge = srcEdge(toSlope(s_q.dly.evSlope), s_q.dly.evSrc,
		s_q.prev, cur);
	assign onEdge = srcEdge(toSlope(s_q.dly.onSlope), s_q.dly.onSrc,
		s_q.prev, cur);

	// the line reference has no slope: it fires on its rising crossing
	assign edgeHit = (act.edgeSrc == `SRC_LINE)
		? srcEdge(SLOPE_POS, act.edgeSrc, s_q.prev, cur)
		: srcEdge(act.edgeSlope, act.edgeSrc, s_q.prev, cur);

	// aux and line are not legal glitch sources and read as idle
	assign glLvl = (act.glSrc < `SRC_AUX) ? pick(act.glSrc, cur)
		: (act.glPol == POL_NEG);

	// programmed times clip to what the counters can honour
	assign delayEff = clampCyc(s_q.dly.delayCyc, DLY_MIN_CYC, DLY_MAX);
	assign glWidthEff = clampCyc(act.glWidth, GL_MIN_CYC, GL_MAX);
	assign evEff = (s_q.dly.evCount > `EVCOUNT_MAX) ? `EVCOUNT_MAX
		: s_q.dly.evCount;

	glitch_meter u_glitch
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.lvl      (glLvl),
		.pol      (act.glPol),
		.widthCyc (glWidthEff),
		.hit      (glHit)
	);

	// ************************************************************
	// next state
	// ************************************************************

	always_comb
	begin
		s_d = s_q;
		s_d.trig = 1'b0;
		s_d.prev = cur;
		s_d.hist = {s_q.hist[4:0], serBit};
		if (s_q.fill < `PAT_MAX)
			s_d.fill = s_q.fill + 3'h1;
		s_d.matchQ = match;
		s_d.patBad = !valid;
		s_d.armed = s_q.dState != DLY_ARM;

		// readback echoes the stored words, not the clipped ones
		s_d.rd.mode = s_q.mode;
		s_d.rd.serial = s_q.serial;
		s_d.rd.dly = s_q.dly;
		s_d.rd.stage = s_q.stage[rdStage];

		// delay sequence: arm, wait out events or time, then fire
		case (s_q.dState)
			DLY_ARM:
			begin
				if (s_q.mode == MODE_DELAY && armEdge)
				begin
					s_d.cnt = '0;
					if (!s_q.dly.timedMode && evEff == '0)
						s_d.dState = DLY_WAIT;
					else
						s_d.dState = DLY_COUNT;
				end
			end
			DLY_COUNT:
			begin
				if (s_q.dly.timedMode)
				begin
					s_d.cnt = s_q.cnt + 29'h1;
					if (s_q.cnt + 29'h1 >= delayEff)
						s_d.dState = DLY_WAIT;
				end
				else if (evEdge)
				begin
					s_d.cnt = s_q.cnt + 29'h1;
					if (s_q.cnt + 29'h1 >= {5'h0, evEff})
						s_d.dState = DLY_WAIT;
				end
			end
			DLY_WAIT:
			begin
				if (onEdge)
				begin
					s_d.trig = 1'b1;
					s_d.dState = DLY_ARM;
				end
			end
			default:
				s_d.dState = DLY_ARM;
		endcase
		if (s_q.mode != MODE_DELAY)
			s_d.dState = DLY_ARM;

		// the other modes give one pulse per qualified event
		case (s_q.mode)
			MODE_SERIAL:
				s_d.trig = valid && match && !s_q.matchQ;
			MODE_EDGE:
				s_d.trig = edgeHit;
			MODE_GLITCH:
				s_d.trig = glHit;
			default:
				s_d.trig = s_d.trig;
		endcase

		// a write restarts sequencing so old history cannot match
		if (cfgWr)
		begin
			s_d.mode = cfgIn.mode;
			s_d.serial = cfgIn.serial;
			s_d.dly = cfgIn.dly;
			s_d.stage[cfgStage] = cfgIn.stage;
			s_d.dState = DLY_ARM;
			s_d.fill = '0;
			s_d.trig = 1'b0;
		end
	end

	// clock enable low freezes every flop of the block
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= `RST_SETTINGS;
		else if (clkEn)
			s_q <= s_d;
	end

	assign trigOut = s_q.trig;
	assign patternBad = s_q.patBad;
	assign delayArmed = s_q.armed;
	assign rdOut = s_q.rd;

	// ************************************************************
	// checks
	// ************************************************************

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_readback_stage: assert property (cfgWr && clkEn ##1 clkEn && !cfgWr
		&& rdStage == $past(cfgStage) |=> rdOut.stage == $past(cfgIn.stage, 2))
		else $error("stage settings not read back");
	chk_pattern_store: assert property (cfgWr && clkEn ##1 clkEn && !cfgWr
		|=> rdOut.serial == $past(cfgIn.serial, 2))
		else $error("serial pattern not read back");
	chk_bad_pattern: assert property ($past(s_q.mode) == MODE_SERIAL
		&& patternBad |-> !trigOut)
		else $error("trigger from a refused pattern");
	chk_serial_fire: assert property (clkEn && !cfgWr && s_q.mode == MODE_SERIAL
		&& valid && match && !s_q.matchQ |=> trigOut)
		else $error("serial match did not trigger");
	chk_trig_single: assert property (clkEn && trigOut
		&& s_q.mode == MODE_SERIAL |=> !trigOut)
		else $error("serial trigger longer than one cycle");
	chk_arm_leaves: assert property (clkEn && !cfgWr && s_q.mode == MODE_DELAY
		&& s_q.dState == DLY_ARM && armEdge |=> s_q.dState != DLY_ARM)
		else $error("arming edge ignored");
	chk_event_step: assert property (clkEn && !cfgWr && s_q.mode == MODE_DELAY
		&& s_q.dState == DLY_COUNT && !s_q.dly.timedMode && evEdge
		|=> s_q.cnt == $past(s_q.cnt) + 29'h1)
		else $error("event edge not counted");
	chk_time_step: assert property (clkEn && !cfgWr && s_q.mode == MODE_DELAY
		&& s_q.dState == DLY_COUNT && s_q.dly.timedMode
		|=> s_q.cnt == $past(s_q.cnt) + 29'h1)
		else $error("delay timer stalled");
	chk_delay_fire: assert property (clkEn && !cfgWr && s_q.mode == MODE_DELAY
		&& s_q.dState == DLY_WAIT && onEdge
		|=> trigOut && s_q.dState == DLY_ARM)
		else $error("trigger-on edge missed");
	chk_edge_fire: assert property (clkEn && !cfgWr && s_q.mode == MODE_EDGE
		&& edgeHit |=> trigOut)
		else $error("edge did not trigger");

	cov_serial: cover property (s_q.mode == MODE_SERIAL && trigOut);
	cov_delay: cover property (s_q.mode == MODE_DELAY && trigOut);
	cov_edge_two: cover property (activeStage && s_q.mode == MODE_EDGE && trigOut);
	cov_glitch: cover property (s_q.mode == MODE_GLITCH && trigOut);
endmodule
`default_nettype wire

// *** include/trig_qual_regs.svh ***
// encodings, limits and timing constants of the trigger qualifier
`ifndef TRIG_QUAL_REGS_SVH
`define TRIG_QUAL_REGS_SVH

// index of each source in the combined comparator vector
`define SRC_ANALOG0   5'h00
`define SRC_LOGIC0    5'h04
`define SRC_AUX       5'h14
`define SRC_LINE      5'h15
`define SRC_COUNT     22

// serial pattern symbols, two bits each
`define SYM_ZERO      2'h0
`define SYM_ONE       2'h1
`define SYM_BAD       2'h2
`define SYM_MINUS     2'h3
`define PAT_MAX       3'h6

// largest event count that the delay mode honours
`define EVCOUNT_MAX   24'hF42400

// timing figures in their own units
`define CLK_PERIOD_PS 20000
`define TDLY_MIN_NS   10
`define TDLY_MAX_MS   10000
`define GLITCH_MIN_PS 250
`define GLITCH_MAX_MS 10000

// reset value of the settings
`define RST_SETTINGS  '0

`endif

// *** include/trig_qual_pkg.sv ***
// types shared by the trigger qualifier files
package trig_qual_pkg;

	// index into the combined source vector
	typedef logic [4:0] srcSel_t;

	typedef enum logic [1:0] {
		MODE_SERIAL,
		MODE_DELAY,
		MODE_EDGE,
		MODE_GLITCH
	} trigMode_t;

	typedef enum logic [1:0] {
		SLOPE_POS,
		SLOPE_NEG,
		SLOPE_EITHER
	} slope_t;

	typedef enum logic {
		POL_POS,
		POL_NEG
	} polarity_t;

	typedef enum logic [1:0] {
		DLY_ARM,
		DLY_COUNT,
		DLY_WAIT
	} dlyState_t;

	typedef struct packed {
		logic [11:0] pattern;   // symbol 0 in bits 1:0, sent first
		logic [2:0]  patLen;
		logic        rzCoding;
		polarity_t   pol;
		logic [1:0]  chan;      // analog input 1..4 as 0..3
	} serialCfg_t;

	typedef struct packed {
		srcSel_t     armSrc;
		polarity_t   armSlope;
		srcSel_t     evSrc;
		polarity_t   evSlope;
		logic        timedMode;
		logic [23:0] evCount;
		logic [28:0] delayCyc;
		srcSel_t     onSrc;
		polarity_t   onSlope;
	} delayCfg_t;

	typedef struct packed {
		srcSel_t     edgeSrc;
		slope_t      edgeSlope;
		srcSel_t     glSrc;
		polarity_t   glPol;
		logic [28:0] glWidth;
	} stageCfg_t;

	typedef struct packed {
		trigMode_t   mode;
		serialCfg_t  serial;
		delayCfg_t   dly;
		stageCfg_t   stage;
	} settings_t;

endpackage

// *** verilog/input_sync.sv ***
// two-stage synchroniser for the comparator streams
`timescale 1ns/1ps
`default_nettype none
`include "trig_qual_regs.svh"

module input_sync
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  clkEn,
	input  wire logic [`SRC_COUNT-1:0] din,
	output logic      [`SRC_COUNT-1:0] dout
);
	typedef struct packed {
		logic [`SRC_COUNT-1:0] s1;
		logic [`SRC_COUNT-1:0] s2;
	} syncState_t;

	syncState_t s_q;
	syncState_t s_d;

	// first stage feeds only the second, so metastability stays boxed in
	always_comb
	begin
		s_d = s_q;
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else if (clkEn)
			s_q <= s_d;
	end

	assign dout = s_q.s2;

	chk_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn ##1 clkEn |=> dout == $past(din, 2))
		else $error("synchroniser latency is not two cycles");
endmodule
`default_nettype wire

// *** verilog/glitch_meter.sv ***
// measures pulses of one polarity and flags those narrower than a limit
`timescale 1ns/1ps
`default_nettype none

module glitch_meter
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clkEn,
	input  wire logic                     lvl,
	input  wire trig_qual_pkg::polarity_t pol,
	input  wire logic [28:0]              widthCyc,
	output logic                          hit
);
	import trig_qual_pkg::*;

	typedef struct packed {
		logic        prevAct;
		logic [28:0] cnt;
		logic        hit;
	} glState_t;

	glState_t s_q;
	glState_t s_d;
	logic     act;

	// a negative glitch is a low pulse, so fold polarity into the level
	assign act = lvl ^ (pol == POL_NEG);

	// count the pulse while active, judge it on its trailing edge
	always_comb
	begin
		s_d = s_q;
		s_d.hit = 1'b0;
		s_d.prevAct = act;
		if (act)
		begin
			if (!s_q.prevAct)
				s_d.cnt = 29'h1;
			else if (s_q.cnt != '1)
				s_d.cnt = s_q.cnt + 29'h1;
		end
		else if (s_q.prevAct)
			s_d.hit = s_q.cnt < widthCyc;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else if (clkEn)
			s_q <= s_d;
	end

	assign hit = s_q.hit;

	chk_glitch_narrow: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && s_q.prevAct && !act && s_q.cnt < widthCyc |=> hit)
		else $error("narrow pulse not flagged");
	chk_glitch_wide: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && s_q.prevAct && !act && s_q.cnt >= widthCyc |=> !hit)
		else $error("wide pulse flagged as glitch");
endmodule
`default_nettype wire

// *** testbench/comp_model.sv ***
// behavioural model of the input comparators feeding the qualifier
`timescale 1ns/1ps
`default_nettype none

module comp_model
(
	input  wire logic        clk,
	input  wire logic [21:0] level,
	output logic      [3:0]  analogIn,
	output logic      [15:0] logicIn,
	output logic             auxIn,
	output logic             lineIn
);
	// decision lands one cycle after the level moves, like a real slicer
	always_ff @(posedge clk)
	begin
		analogIn <= level[3:0];
		logicIn  <= level[19:4];
		auxIn    <= level[20];
		lineIn   <= level[21];
	end
endmodule

`default_nettype wire

// *** testbench/scope_trigger_qualifier_tb.sv ***
// self-checking bench of the trigger qualifier
`timescale 1ns/1ps
`default_nettype none

module scope_trigger_qualifier_tb;
	import trig_qual_pkg::*;
	localparam int SW = $bits(settings_t);
	// edge table: source code, slope, pin pulsed, expected trigger cycles
	localparam int ESRC[6] = '{1, 11, 20, 21, 21, 11};
	localparam int ESLP[6] = '{0, 1, 2, 2, 1, 0};
	localparam int EPIN[6] = '{1, 11, 20, 21, 21, 5};
	localparam int ECNT[6] = '{1, 1, 2, 1, 1, 0};
	// pattern table: bad flag, rz, negative polarity, two symbols
	localparam logic [15:0] VT[8] = '{16'h0004, 16'h8001, 16'h2001,
		16'hA004, 16'h4004, 16'hC003, 16'h6003, 16'hE005};

	logic        clk;
	logic        rst_n;
	logic        clkEn;
	logic        cfgWr;
	logic        cfgStage;
	logic        rdStage;
	logic        activeStage;
	settings_t   cfgIn;
	settings_t   rdOut;
	settings_t   s;
	settings_t   sA;
	settings_t   sB;
	logic [21:0] lvl;
	logic [3:0]  analogIn;
	logic [15:0] logicIn;
	logic        auxIn;
	logic        lineIn;
	logic        trigOut;
	logic        patternBad;
	logic        delayArmed;
	int          trigCnt;
	int          numErrors;
	int          nCompared;
	int          cycles;

	comp_model i_comp_model (.clk(clk), .level(lvl), .analogIn(analogIn),
		.logicIn(logicIn), .auxIn(auxIn), .lineIn(lineIn));

	trig_qualifier #(.DELAY_MAX_CYC(1000), .GLITCH_MAX_CYC(1000))
	i_trig_qualifier (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
		.analogIn(analogIn), .logicIn(logicIn), .auxIn(auxIn),
		.lineIn(lineIn), .cfgWr(cfgWr), .cfgStage(cfgStage), .cfgIn(cfgIn),
		.rdStage(rdStage), .activeStage(activeStage), .trigOut(trigOut),
		.patternBad(patternBad), .delayArmed(delayArmed), .rdOut(rdOut));

	// ****************************************
	// clock, trigger counter and hang guard
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// counted mid-cycle so the registered pulse is settled
	always @(negedge clk)
	begin
		if (trigOut === 1'b1)
			trigCnt++;
	end

	// a wait that never ends shows up as a run past this ceiling
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			numErrors++;
			summarize();
		end
	end

	// ****************************************
	// access tasks
	// ****************************************
	task automatic check(input logic [SW-1:0] seen, input logic [SW-1:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (numErrors == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one settings write, then room for the two-edge readback latency
	task automatic wr(input settings_t v, input logic stg);
		@(posedge clk);
		cfgWr    <= 1'b1;
		cfgIn    <= v;
		cfgStage <= stg;
		@(posedge clk);
		cfgWr    <= 1'b0;
		tick(3);
	endtask

	// flip one source for w cycles, restore it, leave time for the answer
	task automatic pulse(input int idx, input int w);
		@(posedge clk);
		lvl[idx] <= ~lvl[idx];
		tick(w);
		lvl[idx] <= ~lvl[idx];
		tick(8);
	endtask

	// one symbol per cycle, oldest first
	task automatic bits(input int idx, input logic [2:0] seq);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			lvl[idx] <= seq[i];
		end
		tick(8);
	endtask

	task automatic trigs(input int n);
		check(trigCnt, n);
		trigCnt = 0;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		cfgWr = 1'b0;
		cfgStage = 1'b0;
		rdStage = 1'b0;
		activeStage = 1'b0;
		cfgIn = '0;
		lvl = '0;
		trigCnt = 0;
		numErrors = 0;
		nCompared = 0;
		cycles = 0;
		tick(2);
		@(negedge clk);
		check(rdOut, '0);
		check({trigOut, patternBad, delayArmed}, 3'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(3);
		@(negedge clk);
		check(patternBad, 1'b1);
		// both stage copies read back, the unwritten copy untouched
		sA = settings_t'({9{15'h5A3C}});
		sB = settings_t'({9{15'h25C3}});
		wr(sA, 1'b0);
		wr(sB, 1'b1);
		rdStage <= 1'b1;
		tick(3);
		@(negedge clk);
		check(rdOut, sB);
		@(posedge clk);
		rdStage <= 1'b0;
		tick(3);
		@(negedge clk);
		check(rdOut.stage, sA.stage);
		// pattern validity for every coding and polarity
		s = '0;
		s.mode = MODE_SERIAL;
		s.serial.patLen = 3'h2;
		s.serial.chan = 2'h2;
		for (int i = 0; i < 8; i++)
		begin
			s.serial.pattern = VT[i][11:0];
			s.serial.rzCoding = VT[i][14];
			s.serial.pol = polarity_t'(VT[i][13]);
			wr(s, 1'b0);
			@(negedge clk);
			check(patternBad, VT[i][15]);
		end
		// invalid stored pattern must not fire
		s = '0;
		s.mode = MODE_SERIAL;
		s.serial.patLen = 3'h2;
		s.serial.chan = 2'h2;
		s.serial.pattern = 12'h005;
		wr(s, 1'b0);
		trigCnt = 0;
		bits(2, 3'h3);
		trigs(0);
		// valid three-symbol pattern 0,1,1 on analog input 3 only
		s.serial.patLen = 3'h3;
		s.serial.pattern = 12'h014;
		wr(s, 1'b0);
		bits(0, 3'h3);
		trigs(0);
		bits(2, 3'h3);
		trigs(1);
		// edge mode over sources and slopes
		for (int i = 0; i < 6; i++)
		begin
			s = '0;
			s.mode = MODE_EDGE;
			s.stage.edgeSrc = srcSel_t'(ESRC[i]);
			s.stage.edgeSlope = slope_t'(ESLP[i]);
			wr(s, 1'b0);
			trigCnt = 0;
			pulse(EPIN[i], 3);
			trigs(ECNT[i]);
		end
		// second stage copy drives detection when selected
		s.stage.edgeSrc = 5'h01;
		s.stage.edgeSlope = SLOPE_POS;
		wr(s, 1'b0);
		s.stage.edgeSrc = 5'h0B;
		wr(s, 1'b1);
		activeStage <= 1'b1;
		trigCnt = 0;
		pulse(1, 3);
		trigs(0);
		pulse(11, 3);
		trigs(1);
		activeStage <= 1'b0;
		// glitch width boundary and polarity
		s = '0;
		s.mode = MODE_GLITCH;
		s.stage.glSrc = 5'h03;
		s.stage.glWidth = 29'h5;
		wr(s, 1'b0);
		trigCnt = 0;
		pulse(3, 4);
		trigs(1);
		pulse(3, 5);
		trigs(0);
		s.stage.glPol = POL_NEG;
		wr(s, 1'b0);
		trigCnt = 0;
		pulse(3, 2);
		trigs(0);
		s.stage.glPol = POL_POS;
		s.stage.glSrc = 5'h07;
		wr(s, 1'b0);
		trigCnt = 0;
		pulse(7, 2);
		trigs(1);
		// delay by three falling events on logic input 0
		s = '0;
		s.mode = MODE_DELAY;
		s.dly.evSrc = 5'h04;
		s.dly.evSlope = POL_NEG;
		s.dly.evCount = 24'h3;
		s.dly.onSrc = 5'h01;
		wr(s, 1'b0);
		trigCnt = 0;
		pulse(1, 3);
		trigs(0);
		pulse(0, 3);
		@(negedge clk);
		check(delayArmed, 1'b1);
		pulse(4, 3);
		pulse(4, 3);
		pulse(1, 3);
		trigs(0);
		pulse(4, 3);
		pulse(1, 3);
		trigs(1);
		@(negedge clk);
		check(delayArmed, 1'b0);
		// delay by thirty cycles of time
		s.dly.timedMode = 1'b1;
		s.dly.delayCyc = 29'h1E;
		wr(s, 1'b0);
		trigCnt = 0;
		pulse(0, 2);
		pulse(1, 2);
		trigs(0);
		tick(30);
		pulse(1, 2);
		trigs(1);
		// a write offered while the enable is low must not be stored
		clkEn <= 1'b0;
		wr(sA, 1'b0);
		clkEn <= 1'b1;
		tick(3);
		@(negedge clk);
		check(rdOut, s);
		summarize();
	end
endmodule

`default_nettype wire
